// ---- include/abc_pkg.sv ----
// shared constants for the area bus configuration register bank
package abc_pkg;
  // register index; the byte address is four times the index
  localparam logic [1:0] ABC_IDX_AREA_BUS_WIDTH = 2'h0;
  localparam logic [1:0] ABC_IDX_AREA_ACCESS_STATES = 2'h1;
  localparam logic [1:0] ABC_IDX_WAIT_COUNT_UPPER = 2'h2;
  localparam logic [1:0] ABC_IDX_WAIT_COUNT_LOWER = 2'h3;
  localparam int ABC_ADDR_W = 4;
  localparam int ABC_IDX_LSB = 2;
  localparam int ABC_AREAS = 8;
  // power-on and hardware standby values
  localparam logic [7:0] ABC_RST_WIDTH_DEFAULT = 8'hff;
  localparam logic [7:0] ABC_RST_WIDTH_MODE4 = 8'h00;
  localparam logic [7:0] ABC_RST_ACCESS_STATES = 8'hff;
  localparam logic [7:0] ABC_RST_WAIT_UPPER = 8'hff;
  localparam logic [7:0] ABC_RST_WAIT_LOWER = 8'hff;
  localparam logic [2:0] ABC_MODE_ALL_ZERO_WIDTH = 3'h4;
  // upper wait register holds areas 7..4, two bits each, area 4 lowest
  localparam int ABC_WAIT_FIELD_W = 2;
  localparam int ABC_UPPER_FIRST_AREA = 4;
  // cycles the strap sampler waits after reset release; the mode pins need
  // three stages plus one agreeing edge, so fewer would latch the reset level
  localparam logic [2:0] ABC_STRAP_SETTLE = 3'h5;
  localparam logic [1:0] ABC_RESP_OKAY = 2'h0;
  localparam logic [1:0] ABC_RESP_SLVERR = 2'h2;
endpackage : abc_pkg

// ---- logic/abc_regs.sv ----
// area bus configuration registers with an axi4-lite slave port
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
// How it works
// - per-area width bit: 0 selects 16-bit, 1 selects 8-bit external access.
// - on-chip memory and internal i/o accesses keep their fixed width.
// - normal mode ignores width bits 7..1; area 0 bit sets width.
// - power-on/hw standby load width all ones, or all zeros in mode 4.
// - manual reset and software standby leave all registers untouched.
// - access-state bit 0 gives 2-state no waits, 1 gives 3-state with waits.
// - on-chip memory and internal i/o keep their fixed access states.
// - normal mode ignores access-state bits 7..1; area 0 bit decides.
// - power-on/hw standby load access-state register with all ones.
// - 3-state area inserts 0..3 program waits per its two-bit field.
// - upper wait register: bits 7:6 area 7 down to 1:0 area 4.
// - no program waits on on-chip memory or internal i/o accesses.
// - normal mode uses only the area 0 wait field.
// - power-on/hw standby load both wait registers with all ones.
module abc_regs
  import abc_pkg::*;
(
  input wire logic I_CLK, // 200 mhz clock
  input wire logic I_RST_B, // power-on reset, active low
  input wire logic I_HW_STANDBY, // hardware standby pin, active high
  input wire logic [2:0] I_MODE, // operating mode pins
  input wire logic I_ADVANCED, // 1 advanced mode, 0 normal mode
  input wire logic I_CYC_START, // pulse: bus cycle begins
  input wire logic [2:0] I_CYC_AREA, // area of that cycle
  input wire logic I_CYC_INTERNAL, // cycle targets on-chip memory or i/o
  output logic O_CYC_VALID, // pulse: cycle settings below updated
  output logic O_CYC_8BIT, // 1 8-bit bus, 0 16-bit bus
  output logic O_CYC_3STATE, // 1 3-state access, 0 2-state
  output logic [1:0] O_CYC_WAITS, // program wait states
  output logic O_WAIT_PIN_EN, // external wait request may be honoured
  input wire logic [ABC_ADDR_W-1:0] S_AXI_AWADDR, // write address
  input wire logic S_AXI_AWVALID, // write address valid
  output logic S_AXI_AWREADY, // write address ready
  input wire logic [31:0] S_AXI_WDATA, // write data
  input wire logic [3:0] S_AXI_WSTRB, // write strobes
  input wire logic S_AXI_WVALID, // write data valid
  output logic S_AXI_WREADY, // write data ready
  output logic [1:0] S_AXI_BRESP, // write response
  output logic S_AXI_BVALID, // write response valid
  input wire logic S_AXI_BREADY, // write response ready
  input wire logic [ABC_ADDR_W-1:0] S_AXI_ARADDR, // read address
  input wire logic S_AXI_ARVALID, // read address valid
  output logic S_AXI_ARREADY, // read address ready
  output logic [31:0] S_AXI_RDATA, // read data
  output logic [1:0] S_AXI_RRESP, // read response
  output logic S_AXI_RVALID, // read data valid
  input wire logic S_AXI_RREADY // read data ready
);

  // valid when the byte address names one of the four registers
  function automatic logic addr_mapped(input logic [ABC_ADDR_W-1:0] a);
    logic ok;
    ok = 1'b0;
    if (a[ABC_IDX_LSB-1:0] == 2'h0) begin
      ok = 1'b1;
    end
    return ok;
  endfunction : addr_mapped

  // reset release and pin synchronisers
  logic [1:0] rst_sync;
  logic rst_n;
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  logic [3:0] pin_s1, pin_s2, pin_s3, pin_lvl, next_pin_lvl;
  always_comb begin
    next_pin_lvl = pin_lvl;
    for (int i = 0; i < 4; i++) begin
      // a change counts only once the last two stages agree
      if (pin_s2[i] == pin_s3[i]) begin
        next_pin_lvl[i] = pin_s3[i];
      end
    end
  end
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      pin_s3 <= 4'h0;
      pin_lvl <= 4'h0;
    end else begin
      pin_s1 <= {I_HW_STANDBY, I_MODE};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_lvl <= next_pin_lvl;
    end
  end

  logic standby;
  logic [2:0] mode;
  logic [7:0] width_default;
  assign standby = pin_lvl[3];
  assign mode = pin_lvl[2:0];
  assign width_default = (mode == ABC_MODE_ALL_ZERO_WIDTH) ?
    ABC_RST_WIDTH_MODE4 : ABC_RST_WIDTH_DEFAULT;

  // register file and axi4-lite slave
  logic [7:0] area_bus_width, next_area_bus_width;
  logic [7:0] area_access_states, next_area_access_states;
  logic [7:0] wait_count_upper_areas, next_wait_count_upper_areas;
  logic [7:0] wait_count_lower_areas, next_wait_count_lower_areas;
  logic [2:0] strap_cnt, next_strap_cnt;
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [ABC_ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [7:0] w_data, next_w_data;
  logic w_lane0, next_w_lane0;
  logic awready, next_awready, wready, next_wready;
  logic bvalid, next_bvalid, arready, next_arready, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic [7:0] rd_val;
  logic [1:0] rd_idx, wr_idx;

  assign rd_idx = S_AXI_ARADDR[ABC_IDX_LSB+1:ABC_IDX_LSB];
  assign wr_idx = aw_addr[ABC_IDX_LSB+1:ABC_IDX_LSB];

  always_comb begin
    if (rd_idx == ABC_IDX_AREA_BUS_WIDTH) begin
      rd_val = area_bus_width;
    end else if (rd_idx == ABC_IDX_AREA_ACCESS_STATES) begin
      rd_val = area_access_states;
    end else if (rd_idx == ABC_IDX_WAIT_COUNT_UPPER) begin
      rd_val = wait_count_upper_areas;
    end else begin
      rd_val = wait_count_lower_areas;
    end
  end

  always_comb begin
    next_area_bus_width = area_bus_width;
    next_area_access_states = area_access_states;
    next_wait_count_upper_areas = wait_count_upper_areas;
    next_wait_count_lower_areas = wait_count_lower_areas;
    next_strap_cnt = strap_cnt;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_lane0 = w_lane0;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_arready = 1'b0;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    // address and data are taken independently, in either order
    if (S_AXI_AWVALID && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && wready) begin
      next_w_held = 1'b1;
      next_w_data = S_AXI_WDATA[7:0];
      next_w_lane0 = S_AXI_WSTRB[0];
    end
    if (aw_held && w_held && !bvalid) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = addr_mapped(aw_addr) ? ABC_RESP_OKAY : ABC_RESP_SLVERR;
      // only lane 0 carries register bits; upper lanes are ignored
      if (addr_mapped(aw_addr) && w_lane0) begin
        if (wr_idx == ABC_IDX_AREA_BUS_WIDTH) begin
          next_area_bus_width = w_data;
        end else if (wr_idx == ABC_IDX_AREA_ACCESS_STATES) begin
          next_area_access_states = w_data;
        end else if (wr_idx == ABC_IDX_WAIT_COUNT_UPPER) begin
          next_wait_count_upper_areas = w_data;
        end else begin
          next_wait_count_lower_areas = w_data;
        end
      end
    end else if (bvalid && S_AXI_BREADY) begin
      next_bvalid = 1'b0;
    end
    if (S_AXI_ARVALID && arready) begin
      next_rvalid = 1'b1;
      next_rdata = addr_mapped(S_AXI_ARADDR) ? {24'h0, rd_val} : 32'h0;
      next_rresp = addr_mapped(S_AXI_ARADDR) ? ABC_RESP_OKAY : ABC_RESP_SLVERR;
    end else if (rvalid && S_AXI_RREADY) begin
      next_rvalid = 1'b0;
    end
    if (!arready && !next_rvalid && !rvalid) begin
      next_arready = 1'b1;
    end
    // width reset value waits for the mode pins to pass the synchroniser
    if (strap_cnt != ABC_STRAP_SETTLE) begin
      next_strap_cnt = strap_cnt + 3'h1;
      if (next_strap_cnt == ABC_STRAP_SETTLE) begin
        next_area_bus_width = width_default;
      end
    end
    // hardware standby reinitialises; manual reset has no input here
    if (standby) begin
      next_area_bus_width = width_default;
      next_area_access_states = ABC_RST_ACCESS_STATES;
      next_wait_count_upper_areas = ABC_RST_WAIT_UPPER;
      next_wait_count_lower_areas = ABC_RST_WAIT_LOWER;
    end
  end

  // one write in flight: ready drops while a beat is held
  assign next_awready = !next_aw_held && !(S_AXI_AWVALID && awready);
  assign next_wready = !next_w_held && !(S_AXI_WVALID && wready);

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      area_bus_width <= ABC_RST_WIDTH_DEFAULT;
      area_access_states <= ABC_RST_ACCESS_STATES;
      wait_count_upper_areas <= ABC_RST_WAIT_UPPER;
      wait_count_lower_areas <= ABC_RST_WAIT_LOWER;
      strap_cnt <= 3'h0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 8'h0;
      w_lane0 <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= ABC_RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rresp <= ABC_RESP_OKAY;
      rdata <= 32'h0;
    end else begin
      area_bus_width <= next_area_bus_width;
      area_access_states <= next_area_access_states;
      wait_count_upper_areas <= next_wait_count_upper_areas;
      wait_count_lower_areas <= next_wait_count_lower_areas;
      strap_cnt <= next_strap_cnt;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_lane0 <= next_w_lane0;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  assign S_AXI_AWREADY = awready;
  assign S_AXI_WREADY = wready;
  assign S_AXI_BVALID = bvalid;
  assign S_AXI_BRESP = bresp;
  assign S_AXI_ARREADY = arready;
  assign S_AXI_RVALID = rvalid;
  assign S_AXI_RRESP = rresp;
  assign S_AXI_RDATA = rdata;

  // per-area wait fields gathered from both wait registers
  logic [15:0] wait_all;
  logic [1:0] area_wait [ABC_AREAS];
  assign wait_all = {wait_count_upper_areas, wait_count_lower_areas};
  for (genvar g = 0; g < ABC_AREAS; g++) begin : g_wait
    assign area_wait[g] =
      wait_all[g*ABC_WAIT_FIELD_W +: ABC_WAIT_FIELD_W];
  end

  // settings latched at cycle start so a write never changes a live cycle
  logic cyc_valid, next_cyc_valid, cyc_8bit, next_cyc_8bit;
  logic cyc_3state, next_cyc_3state, wait_en, next_wait_en;
  logic [1:0] cyc_waits, next_cyc_waits;
  logic [2:0] eff_area;
  assign eff_area = I_ADVANCED ? I_CYC_AREA : 3'h0;

  always_comb begin
    next_cyc_valid = I_CYC_START;
    next_cyc_8bit = cyc_8bit;
    next_cyc_3state = cyc_3state;
    next_cyc_waits = cyc_waits;
    next_wait_en = wait_en;
    if (I_CYC_START) begin
      if (I_CYC_INTERNAL) begin
        // fixed internal path: 16-bit, 2-state, never a program wait
        next_cyc_8bit = 1'b0;
        next_cyc_3state = 1'b0;
        next_cyc_waits = 2'h0;
        next_wait_en = 1'b0;
      end else begin
        next_cyc_8bit = area_bus_width[eff_area];
        next_cyc_3state = area_access_states[eff_area];
        // waits only count in 3-state areas
        next_cyc_waits = area_access_states[eff_area] ?
          area_wait[eff_area] : 2'h0;
        next_wait_en = area_access_states[eff_area];
      end
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cyc_valid <= 1'b0;
      cyc_8bit <= 1'b0;
      cyc_3state <= 1'b0;
      cyc_waits <= 2'h0;
      wait_en <= 1'b0;
    end else begin
      cyc_valid <= next_cyc_valid;
      cyc_8bit <= next_cyc_8bit;
      cyc_3state <= next_cyc_3state;
      cyc_waits <= next_cyc_waits;
      wait_en <= next_wait_en;
    end
  end

  assign O_CYC_VALID = cyc_valid;
  assign O_CYC_8BIT = cyc_8bit;
  assign O_CYC_3STATE = cyc_3state;
  assign O_CYC_WAITS = cyc_waits;
  assign O_WAIT_PIN_EN = wait_en;

endmodule : abc_regs

// ---- bench/abc_regs_chk.sv ----
// checker for the cycle settings and bus answers of the register bank
`timescale 1ns/1ps
module abc_regs_chk
  import abc_pkg::*;
(
  input wire logic I_CLK, // clock
  input wire logic I_RST_B, // reset, active low
  input wire logic I_CYC_START, // cycle start
  input wire logic I_CYC_INTERNAL, // internal target
  input wire logic O_CYC_VALID, // settings pulse
  input wire logic O_CYC_8BIT, // byte bus
  input wire logic O_CYC_3STATE, // three-state access
  input wire logic [1:0] O_CYC_WAITS, // program waits
  input wire logic O_WAIT_PIN_EN, // wait request allowed
  input wire logic S_AXI_ARVALID, // read address valid
  input wire logic S_AXI_ARREADY, // read address ready
  input wire logic [31:0] S_AXI_RDATA, // read data
  input wire logic [1:0] S_AXI_RRESP, // read response
  input wire logic S_AXI_RVALID, // read valid
  input wire logic S_AXI_BVALID, // write response valid
  input wire logic S_AXI_BREADY // write response ready
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_B);
  chk_cyc_answer: assert property (I_CYC_START |=> O_CYC_VALID)
    else $error("no settings after cycle start");
  chk_int_fixed: assert property (I_CYC_START && I_CYC_INTERNAL |=>
    !O_CYC_8BIT && !O_CYC_3STATE && O_CYC_WAITS == 2'h0)
    else $error("internal cycle not fixed");
  chk_two_state: assert property (O_CYC_VALID && !O_CYC_3STATE |->
    O_CYC_WAITS == 2'h0)
    else $error("waits on two-state cycle");
  chk_wait_pin: assert property (O_CYC_VALID |->
    O_WAIT_PIN_EN == O_CYC_3STATE)
    else $error("wait request enable wrong");
  chk_cyc_hold: assert property (!I_CYC_START |=>
    $stable({O_CYC_8BIT, O_CYC_3STATE, O_CYC_WAITS}))
    else $error("settings moved without a cycle");
  chk_rd_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=>
    S_AXI_RVALID)
    else $error("read not answered");
  chk_ar_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address taken while busy");
  chk_b_drop: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response repeated");
  chk_rd_upper: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_err_zero: assert property (S_AXI_RVALID &&
    S_AXI_RRESP == ABC_RESP_SLVERR |-> S_AXI_RDATA == 32'h0)
    else $error("refused read carries data");
endmodule : abc_regs_chk
bind abc_regs abc_regs_chk abc_regs_chk_inst (.I_CLK, .I_RST_B, .I_CYC_START,
  .I_CYC_INTERNAL, .O_CYC_VALID, .O_CYC_8BIT, .O_CYC_3STATE, .O_CYC_WAITS,
  .O_WAIT_PIN_EN, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
  .S_AXI_RVALID, .S_AXI_BVALID, .S_AXI_BREADY);

// ---- bench/abc_ext_mem.sv ----
// external memory model answering with its wait request
`timescale 1ns/1ps
module abc_ext_mem (
  input wire logic i_clk, // clock
  input wire logic i_cyc_valid, // settings pulse
  input wire logic i_wait_en, // wait request allowed
  input wire logic i_slow, // device wants extra waits
  output logic o_wait_req_b // wait request, active low
);
  initial o_wait_req_b = 1'b1;
  // a slow device may only stretch three-state cycles
  always @(posedge i_clk) begin
    if (i_cyc_valid) o_wait_req_b <= !(i_slow && i_wait_en);
  end
endmodule : abc_ext_mem

// ---- bench/area_bus_config_regs_bench.sv ----
// self-checking bench for the area bus configuration registers
`timescale 1ns/1ps
module area_bus_config_regs_bench;
  import abc_pkg::*;
  logic I_CLK = 1'b0, I_RST_B = 1'b0, I_HW_STANDBY = 1'b0, I_ADVANCED = 1'b0;
  logic I_CYC_START = 1'b0, I_CYC_INTERNAL = 1'b0, slow = 1'b0;
  logic [2:0] I_MODE = 3'h1, I_CYC_AREA = 3'h0;
  logic [3:0] S_AXI_AWADDR = 4'h0, S_AXI_ARADDR = 4'h0, S_AXI_WSTRB = 4'h0;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
  logic O_CYC_VALID, O_CYC_8BIT, O_CYC_3STATE, O_WAIT_PIN_EN, wait_b;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0] O_CYC_WAITS, S_AXI_BRESP, S_AXI_RRESP;
  logic [7:0] mreg [4] = '{8'hff, 8'hff, 8'hff, 8'hff};
  integer n_fail = 0, cmp_count = 0, seed = 39;
  logic [31:0] r;
  always #2.5 I_CLK = ~I_CLK;
  abc_regs abc_regs_inst (.*);
  abc_ext_mem abc_ext_mem_inst (.i_clk(I_CLK), .i_cyc_valid(O_CYC_VALID),
    .i_wait_en(O_WAIT_PIN_EN), .i_slow(slow), .o_wait_req_b(wait_b));
  task summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task wchk(input logic [3:0] a, input logic [7:0] d, input logic s);
    int n;
    @(posedge I_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {24'h0, d};
    S_AXI_WSTRB <= {3'h0, s};
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge I_CLK);
      if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID) break;
    end
    if (n == 50) n_fail++;
    if (n == 50) summarize();
    cmp(S_AXI_BRESP, a[1:0] == 2'h0 ? ABC_RESP_OKAY : ABC_RESP_SLVERR);
    S_AXI_BREADY <= 1'b0;
    if (a[1:0] == 2'h0 && s) mreg[a[3:2]] = d;
  endtask : wchk
  task rchk(input logic [3:0] a);
    int n;
    @(posedge I_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge I_CLK);
      if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID) break;
    end
    if (n == 50) n_fail++;
    if (n == 50) summarize();
    cmp(S_AXI_RDATA, a[1:0] == 2'h0 ? {24'h0, mreg[a[3:2]]} : 32'h0);
    cmp(S_AXI_RRESP, a[1:0] == 2'h0 ? ABC_RESP_OKAY : ABC_RESP_SLVERR);
    S_AXI_RREADY <= 1'b0;
  endtask : rchk
  // expected {byte bus, three-state, waits, wait enable}
  function automatic logic [4:0] exp_cyc(logic [2:0] a, logic i, logic v);
    logic [2:0] k;
    logic t;
    logic [15:0] wq;
    k = v ? a : 3'h0;
    t = mreg[1][k];
    wq = {mreg[2], mreg[3]};
    if (i) return 5'h0;
    return {mreg[0][k], t, t ? wq[2*k+:2] : 2'h0, t};
  endfunction : exp_cyc
  task cyc(input logic [2:0] a, input logic i, input logic v, input logic s);
    logic [4:0] e;
    e = exp_cyc(a, i, v);
    @(posedge I_CLK);
    I_CYC_AREA <= a;
    I_CYC_INTERNAL <= i;
    I_ADVANCED <= v;
    slow <= s;
    I_CYC_START <= 1'b1;
    @(posedge I_CLK);
    I_CYC_START <= 1'b0;
    // settings stand from the edge that takes the start; valid lasts one cycle
    #1;
    cmp({O_CYC_VALID, O_CYC_8BIT, O_CYC_3STATE, O_CYC_WAITS, O_WAIT_PIN_EN},
      {1'b1, e});
    @(posedge I_CLK);
    #1;
    cmp(wait_b, !(s && e[0]));
  endtask : cyc
  task rd_all;
    for (int k = 0; k < 4; k++) rchk({k[1:0], 2'h0});
  endtask : rd_all
  initial begin
    repeat (10) @(posedge I_CLK);
    I_RST_B <= 1'b1;
    repeat (10) @(posedge I_CLK);
    rd_all();
    $display("test reset values done");
    wchk(4'h3, 8'h00, 1'b1);
    rchk(4'h1);
    $display("test unaligned done");
    for (int j = 0; j < 30; j++) begin
      r = $random(seed);
      wchk({r[1:0], 2'h0}, r[15:8], r[4] | r[5]);
      rchk({r[3:2], 2'h0});
      cyc(r[18:16], r[19] & r[20], r[21], r[22]);
    end
    $display("test random done");
    wchk(4'h4, 8'hf1, 1'b1);
    wchk(4'h8, 8'h1b, 1'b1);
    for (int k = 0; k < 8; k++) cyc(k[2:0], 1'b0, 1'b1, 1'b1);
    cyc(3'h7, 1'b0, 1'b0, 1'b1);
    cyc(3'h5, 1'b1, 1'b1, 1'b1);
    $display("test area corners done");
    @(posedge I_CLK);
    I_HW_STANDBY <= 1'b1;
    repeat (10) @(posedge I_CLK);
    I_HW_STANDBY <= 1'b0;
    repeat (8) @(posedge I_CLK);
    mreg = '{8'hff, 8'hff, 8'hff, 8'hff};
    rd_all();
    $display("test standby done");
    I_MODE <= ABC_MODE_ALL_ZERO_WIDTH;
    repeat (6) @(posedge I_CLK);
    I_RST_B <= 1'b0;
    repeat (10) @(posedge I_CLK);
    I_RST_B <= 1'b1;
    repeat (12) @(posedge I_CLK);
    mreg[0] = ABC_RST_WIDTH_MODE4;
    rd_all();
    cyc(3'h2, 1'b0, 1'b1, 1'b0);
    $display("test mode four done");
    summarize();
  end
endmodule : area_bus_config_regs_bench
